/* File: rtl/sadc_cfg.svh */
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// register byte offsets
`define SADC_OFF_CTRL      8'h00
`define SADC_OFF_CFG       8'h04
`define SADC_OFF_RES_HI    8'h08
`define SADC_OFF_RES_LO    8'h0C
`define SADC_OFF_STATUS    8'h10
`define SADC_OFF_ANMASK    8'h14
`define SADC_OFF_PORT      8'h18

// control register fields
`define SADC_CTRL_CLKSEL_HI 7
`define SADC_CTRL_CLKSEL_LO 6
`define SADC_CTRL_CHAN_HI   5
`define SADC_CTRL_CHAN_LO   3
`define SADC_CTRL_GO        2
`define SADC_CTRL_ON        0

// configuration and status fields
`define SADC_CFG_FMT        7
`define SADC_STAT_DONE      0
`define SADC_STAT_PWR       1
`define SADC_STAT_BUSY      2

// reset values
`define SADC_CTRL_RST      8'h00
`define SADC_CFG_RST       8'h00
`define SADC_ANMASK_RST    8'h00

// clock select codes and dividers in oscillator periods
`define SADC_CLKSEL_DIV2   2'h0
`define SADC_CLKSEL_DIV8   2'h1
`define SADC_CLKSEL_DIV32  2'h2
`define SADC_CLKSEL_RC     2'h3
`define SADC_DIV2          6'h02
`define SADC_DIV8          6'h08
`define SADC_DIV32         6'h20

// timing counts
`define SADC_TCY_CLKS      3'h4
`define SADC_FIRST_STEP    4'h2
`define SADC_LAST_STEP     4'hB
`define SADC_SETTLE_TADS   2'h2

// bus answers
`define SADC_RESP_OKAY     2'h0
`define SADC_RESP_SLVERR   2'h2

`endif

/* File: rtl/sadc_pkg.sv */
package sadc_pkg;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_FIRST,
    SQ_CONV,
    SQ_SETTLE
  } sadc_phase_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sadc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sadc_axi_rsp_t;

  typedef struct packed {
    logic [9:0] trial;
    logic       hold_connect;
    logic [2:0] channel;
    logic       powered;
  } sadc_ana_t;

endpackage : sadc_pkg

/* File: rtl/sadc_tad_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_tad_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // control
  input  wire logic       restart,
  input  wire logic [1:0] clk_sel,
  input  wire logic       rc_tick,
  // one pulse per bit conversion period
  output var  logic       tad_tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } sadc_tad_state_t;

  sadc_tad_state_t st;
  sadc_tad_state_t next_st;
  logic [5:0]      div;

  always_comb begin
    unique case (clk_sel)
      `SADC_CLKSEL_DIV2: div = `SADC_DIV2;
      `SADC_CLKSEL_DIV8: div = `SADC_DIV8;
      `SADC_CLKSEL_DIV32: div = `SADC_DIV32;
      `SADC_CLKSEL_RC: div = `SADC_DIV2;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.cnt = 6'h01; // [RULE_07]
    end else if (clk_sel == `SADC_CLKSEL_RC) begin
      next_st.tick = rc_tick; // [RULE_02]
    end else if (st.cnt == div - 6'h01) begin
      next_st.cnt = 6'h00;
      next_st.tick = 1'b1; // [RULE_02]
    end else begin
      next_st.cnt = st.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tad_tick = st.tick;

endmodule : sadc_tad_gen

`default_nettype wire

/* File: rtl/sadc_seq.sv */
// Function
// [RULE_01] conversion spans at least twelve bit periods
// [RULE_02] clock select picks /2, /8, /32 or RC
// [RULE_03] software keeps bit period at least 1.6 us
// [RULE_04] clearing go aborts, result pair kept
// [RULE_05] after abort wait two periods, then acquire
// [RULE_06] after completion hold disconnected two periods
// [RULE_07] first segment: one instruction cycle to one period
// [RULE_08] software sets go after turning converter on
// [RULE_09] result justified left or right by format bit
// [RULE_10] unused six result bits load as zero
// [RULE_11] result bytes writable while converter is off
// [RULE_12] sleep conversion only with RC clock
// [RULE_13] RC clock delays start one instruction cycle
// [RULE_14] sleep completion clears go, loads, wakes if enabled
// [RULE_15] sleep completion without interrupt powers down, on stays
// [RULE_16] sleep without RC aborts and powers down
// [RULE_17] analog-configured port pins read as zero
// [RULE_18] conversion ignores channel select and pin direction
// [RULE_19] software waits acquisition time after channel change
// [RULE_20] above 1 MHz use RC only in sleep
// [RULE_21] completion loads result, clears go, sets done flag
// [RULE_22] reset clears control, converter off, conversion aborted
// [RULE_23] bits resolved msb first, one per period
// [RULE_24] go ignored while converter is off
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"

module sadc_seq (
  // clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   NRST,
  // register bus
  input  wire sadc_pkg::sadc_axi_req_t AXI_REQ,
  output var  sadc_pkg::sadc_axi_rsp_t AXI_RSP,
  // system context
  input  wire logic                   SLEEP,
  input  wire logic                   INT_ENABLE,
  input  wire logic                   RC_TICK,
  input  wire logic [7:0]             PORT_PINS,
  // analog front end
  input  wire logic                   COMP_HIGH,
  output var  sadc_pkg::sadc_ana_t    ANA,
  // events
  output var  logic                   DONE_FLAG,
  output var  logic                   WAKE
);
  import sadc_pkg::*;

  typedef struct packed {
    sadc_axi_rsp_t rsp;
    logic          aw_full;
    logic [7:0]    aw_addr;
    logic          w_full;
    logic [7:0]    w_data;
    logic          w_strb;
    logic [1:0]    clk_sel;
    logic [2:0]    chan;
    logic          go;
    logic          on;
    logic          fmt;
    logic [7:0]    anmask;
    logic [7:0]    res_hi;
    logic [7:0]    res_lo;
    logic          done;
    logic          pdown;
    sadc_phase_t   phase;
    logic [2:0]    tcy_cnt;
    logic [3:0]    step;
    logic [1:0]    settle_cnt;
    logic [9:0]    sar;
    sadc_ana_t     ana;
    logic          wake;
  } sadc_seq_state_t;

  sadc_seq_state_t st;
  sadc_seq_state_t next_st;

  logic        tad_tick;
  logic        restart;
  logic        do_write;
  logic        wr_ctrl;
  logic        done_set;
  logic        done_clr;
  logic [9:0]  final_val;
  logic [15:0] justified;
  logic [3:0]  bit_idx;
  logic [31:0] rd_data;
  logic        rd_err;

  ////////////////////////////////////////////////////////////////////////
  // bit period source

  sadc_tad_gen u_tad (
    .clk      (CORE_CLK),
    .nrst     (NRST),
    .restart  (restart),
    .clk_sel  (st.clk_sel),
    .rc_tick  (RC_TICK),
    .tad_tick (tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    unique case (AXI_REQ.araddr)
      `SADC_OFF_CTRL: begin
        rd_data[`SADC_CTRL_CLKSEL_HI:`SADC_CTRL_CLKSEL_LO] = st.clk_sel;
        rd_data[`SADC_CTRL_CHAN_HI:`SADC_CTRL_CHAN_LO] = st.chan;
        rd_data[`SADC_CTRL_GO] = st.go;
        rd_data[`SADC_CTRL_ON] = st.on; // [RULE_15] [RULE_16]
      end
      `SADC_OFF_CFG: rd_data[`SADC_CFG_FMT] = st.fmt;
      `SADC_OFF_RES_HI: rd_data[7:0] = st.res_hi;
      `SADC_OFF_RES_LO: rd_data[7:0] = st.res_lo;
      `SADC_OFF_STATUS: begin
        rd_data[`SADC_STAT_DONE] = st.done;
        rd_data[`SADC_STAT_PWR] = st.ana.powered;
        rd_data[`SADC_STAT_BUSY] = (st.phase != SQ_IDLE);
      end
      `SADC_OFF_ANMASK: rd_data[7:0] = st.anmask;
      `SADC_OFF_PORT: rd_data[7:0] = PORT_PINS & ~st.anmask; // [RULE_17]
      default: rd_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // result shaping

  always_comb begin
    final_val = COMP_HIGH ? st.ana.trial : st.sar;
    // format bit set gives right justification
    if (st.fmt) begin
      justified = {6'h00, final_val}; // [RULE_09] [RULE_10]
    end else begin
      justified = {final_val, 6'h00}; // [RULE_09] [RULE_10]
    end
  end

  assign bit_idx = `SADC_LAST_STEP - next_st.step;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.wake = 1'b0;
    restart = 1'b0;
    done_set = 1'b0;
    done_clr = 1'b0;
    do_write = st.aw_full && st.w_full && !st.rsp.bvalid;
    wr_ctrl = do_write && st.w_strb && (st.aw_addr == `SADC_OFF_CTRL);

    // bus: address and data are taken independently
    if (AXI_REQ.awvalid && st.rsp.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = AXI_REQ.awaddr;
      next_st.rsp.awready = 1'b0;
    end
    if (AXI_REQ.wvalid && st.rsp.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = AXI_REQ.wdata[7:0];
      next_st.w_strb = AXI_REQ.wstrb[0];
      next_st.rsp.wready = 1'b0;
    end
    if (st.rsp.bvalid && AXI_REQ.bready) begin
      next_st.rsp.bvalid = 1'b0;
      next_st.rsp.awready = 1'b1;
      next_st.rsp.wready = 1'b1;
    end
    if (AXI_REQ.arvalid && st.rsp.arready) begin
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rd_data;
      next_st.rsp.rresp = rd_err ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
    end
    if (st.rsp.rvalid && AXI_REQ.rready) begin
      next_st.rsp.rvalid = 1'b0;
      next_st.rsp.arready = 1'b1;
    end

    // conversion sequence
    unique case (st.phase)
      SQ_IDLE: begin
        next_st.step = 4'h0;
      end
      SQ_FIRST: begin
        // at least one instruction cycle, ends at the next bit period
        if (st.tcy_cnt != `SADC_TCY_CLKS) begin
          next_st.tcy_cnt = st.tcy_cnt + 3'h1; // [RULE_07] [RULE_13]
        end else if (tad_tick) begin
          next_st.phase = SQ_CONV; // [RULE_07]
          next_st.step = 4'h0;
          next_st.sar = 10'h000;
        end
      end
      SQ_CONV: begin
        if (tad_tick) begin
          // channel and pin direction play no part here
          if (st.step >= `SADC_FIRST_STEP) begin
            next_st.sar = final_val; // [RULE_23] [RULE_18]
          end
          if (st.step == `SADC_LAST_STEP) begin
            next_st.res_hi = justified[15:8]; // [RULE_21] [RULE_01]
            next_st.res_lo = justified[7:0]; // [RULE_21]
            next_st.go = 1'b0; // [RULE_21] [RULE_14]
            done_set = 1'b1; // [RULE_21]
            next_st.phase = SQ_SETTLE; // [RULE_06]
            next_st.settle_cnt = 2'h0;
            if (SLEEP && INT_ENABLE) begin
              next_st.wake = 1'b1; // [RULE_14]
            end else if (SLEEP) begin
              next_st.pdown = 1'b1; // [RULE_15]
            end
          end else begin
            next_st.step = st.step + 4'h1; // [RULE_23]
          end
        end
      end
      SQ_SETTLE: begin
        if (tad_tick) begin
          if (st.settle_cnt == `SADC_SETTLE_TADS - 2'h1) begin
            next_st.phase = SQ_IDLE; // [RULE_05] [RULE_06]
          end else begin
            next_st.settle_cnt = st.settle_cnt + 2'h1;
          end
        end
      end
    endcase

    // register writes other than the done clear take priority over the sequence
    if (do_write) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = `SADC_RESP_OKAY;
      if (st.w_strb) begin
        unique case (st.aw_addr)
          `SADC_OFF_CTRL: begin
            next_st.clk_sel = st.w_data[`SADC_CTRL_CLKSEL_HI:`SADC_CTRL_CLKSEL_LO];
            next_st.chan = st.w_data[`SADC_CTRL_CHAN_HI:`SADC_CTRL_CHAN_LO];
            next_st.on = st.w_data[`SADC_CTRL_ON];
          end
          `SADC_OFF_CFG: next_st.fmt = st.w_data[`SADC_CFG_FMT];
          `SADC_OFF_RES_HI: begin
            if (!st.on) begin
              next_st.res_hi = st.w_data; // [RULE_11]
            end
          end
          `SADC_OFF_RES_LO: begin
            if (!st.on) begin
              next_st.res_lo = st.w_data; // [RULE_11]
            end
          end
          `SADC_OFF_STATUS: done_clr = st.w_data[`SADC_STAT_DONE];
          `SADC_OFF_ANMASK: next_st.anmask = st.w_data;
          default: next_st.rsp.bresp = `SADC_RESP_SLVERR;
        endcase
      end else if (!((st.aw_addr == `SADC_OFF_CTRL) || (st.aw_addr == `SADC_OFF_CFG)
                 || (st.aw_addr == `SADC_OFF_RES_HI) || (st.aw_addr == `SADC_OFF_RES_LO)
                 || (st.aw_addr == `SADC_OFF_STATUS) || (st.aw_addr == `SADC_OFF_ANMASK)
                 || (st.aw_addr == `SADC_OFF_PORT))) begin
        next_st.rsp.bresp = `SADC_RESP_SLVERR;
      end
    end

    if (wr_ctrl) begin
      // start uses the old on bit, so on and go in one write only turns the converter on
      if (st.w_data[`SADC_CTRL_GO] && st.on && st.w_data[`SADC_CTRL_ON]
          && (st.phase == SQ_IDLE) && !st.go && !st.pdown
          && !(SLEEP && (st.w_data[`SADC_CTRL_CLKSEL_HI:`SADC_CTRL_CLKSEL_LO]
                         != `SADC_CLKSEL_RC))) begin
        next_st.go = 1'b1; // [RULE_24] [RULE_12]
        next_st.phase = SQ_FIRST; // [RULE_07]
        next_st.tcy_cnt = 3'h0; // [RULE_13]
        restart = 1'b1;
      end else if (!st.w_data[`SADC_CTRL_GO] && st.go) begin
        next_st.go = 1'b0; // [RULE_04]
        next_st.res_hi = st.res_hi; // [RULE_04]
        next_st.res_lo = st.res_lo; // [RULE_04]
        done_set = 1'b0; // [RULE_04]
        next_st.wake = 1'b0;
        next_st.phase = SQ_SETTLE; // [RULE_05]
        next_st.settle_cnt = 2'h0;
        restart = 1'b1;
      end
      if (!st.w_data[`SADC_CTRL_ON]) begin
        next_st.go = 1'b0;
        next_st.phase = SQ_IDLE;
      end
    end

    // sleep with a non-RC clock aborts and powers down, on bit kept
    if (SLEEP && st.on && (next_st.clk_sel != `SADC_CLKSEL_RC)) begin
      next_st.pdown = 1'b1; // [RULE_16] [RULE_12]
      if (next_st.go) begin
        next_st.go = 1'b0; // [RULE_16]
        next_st.phase = SQ_IDLE;
        done_set = 1'b0;
        next_st.res_hi = st.res_hi;
        next_st.res_lo = st.res_lo;
      end
    end else if (!SLEEP) begin
      next_st.pdown = 1'b0;
    end

    // a completion in the clearing cycle still sets the flag
    next_st.done = (st.done && !done_clr) || done_set;

    // analog side outputs, all registered
    next_st.ana.channel = next_st.chan;
    next_st.ana.powered = next_st.on && !next_st.pdown;
    next_st.ana.hold_connect = next_st.ana.powered && (next_st.phase == SQ_IDLE); // [RULE_06]
    if ((next_st.phase == SQ_CONV) && (next_st.step >= `SADC_FIRST_STEP)) begin
      next_st.ana.trial = next_st.sar | (10'h001 << bit_idx); // [RULE_23]
    end else begin
      next_st.ana.trial = 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0; // [RULE_22]
      st.rsp.awready <= 1'b1;
      st.rsp.wready <= 1'b1;
      st.rsp.arready <= 1'b1;
      st.clk_sel <= 2'(`SADC_CTRL_RST >> `SADC_CTRL_CLKSEL_LO);
      st.fmt <= 1'(`SADC_CFG_RST >> `SADC_CFG_FMT);
      st.anmask <= `SADC_ANMASK_RST;
      st.phase <= SQ_IDLE; // [RULE_22]
    end else begin
      st <= next_st;
    end
  end

  assign AXI_RSP = st.rsp;
  assign ANA = st.ana;
  assign DONE_FLAG = st.done;
  assign WAKE = st.wake;

endmodule : sadc_seq

`default_nettype wire

/* File: sim/sadc_seq_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sadc_seq_chk (
  // clock and reset
  input wire logic                    CORE_CLK,
  input wire logic                    NRST,
  // bus and context
  input wire sadc_pkg::sadc_axi_req_t AXI_REQ,
  input wire sadc_pkg::sadc_axi_rsp_t AXI_RSP,
  input wire logic                    SLEEP,
  input wire logic                    INT_ENABLE,
  // observed outputs
  input wire sadc_pkg::sadc_ana_t     ANA,
  input wire logic                    DONE_FLAG,
  input wire logic                    WAKE
);
  import sadc_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////
  sequence s_wr_taken;
    AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
  endsequence
  sequence s_hold_off;
    !ANA.hold_connect [*2];
  endsequence
  // skipped in sleep: a powered-down converter need not reconnect
  chk_settle_hold: assert property ($rose(DONE_FLAG) && !SLEEP |->
    s_hold_off ##[1:300] ANA.hold_connect) else $error("hold reconnect wrong");
  chk_trial_idle: assert property (ANA.hold_connect |-> ANA.trial == 10'h000)
    else $error("trial code while acquiring");
  chk_wake_pulse: assert property (WAKE |-> DONE_FLAG && $past(INT_ENABLE) ##1 !WAKE)
    else $error("wake pulse wrong");
  chk_power_back: assert property ($rose(ANA.powered) |-> !SLEEP)
    else $error("converter powered in sleep");
  chk_read_answer: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=>
    AXI_RSP.rvalid && !AXI_RSP.arready) else $error("read answer late");
  chk_read_release: assert property (AXI_RSP.rvalid && AXI_REQ.rready |=>
    !AXI_RSP.rvalid ##[0:1] AXI_RSP.arready) else $error("read release wrong");
  chk_write_answer: assert property (s_wr_taken |=>
    !AXI_RSP.awready ##[0:1] AXI_RSP.bvalid) else $error("write answer late");
  chk_write_release: assert property (AXI_RSP.bvalid && AXI_REQ.bready |=>
    !AXI_RSP.bvalid ##[0:1] AXI_RSP.awready) else $error("write release wrong");
endmodule : sadc_seq_chk

bind sadc_seq sadc_seq_chk sadc_seq_chk_inst (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
  .SLEEP(SLEEP), .INT_ENABLE(INT_ENABLE), .ANA(ANA), .DONE_FLAG(DONE_FLAG), .WAKE(WAKE)
);
`default_nettype wire

/* File: sim/sadc_seq_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"
`define CK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, e); end end
module sadc_seq_tb_top;
  import sadc_pkg::*;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  sadc_axi_req_t rq = '0;
  sadc_axi_rsp_t rs;
  logic          sleep = 1'b0;
  logic          inten = 1'b0;
  logic          rctick = 1'b0;
  logic [7:0]    pins = 8'hA5;
  logic          comp = 1'b0;
  sadc_ana_t     ana;
  logic          done;
  logic          wake;
  logic [9:0]    tgt = 10'h000;
  logic [2:0]    rcc = 3'h0;
  logic [31:0]   d;
  logic [1:0]    r;
  logic [15:0]   last;
  logic          fmt = 1'b0;
  int            failures = 0;
  int            samples_checked = 0;
  int            n;
  int            nwake = 0;
  int            w0;
  always #2.5 clk = ~clk;
  sadc_seq sadc_seq_inst (
    .CORE_CLK(clk), .NRST(nrst), .AXI_REQ(rq), .AXI_RSP(rs), .SLEEP(sleep),
    .INT_ENABLE(inten), .RC_TICK(rctick), .PORT_PINS(pins), .COMP_HIGH(comp),
    .ANA(ana), .DONE_FLAG(done), .WAKE(wake)
  );
  // rc tick every 8 clocks keeps each step long enough for the comparator lag
  always @(posedge clk) begin
    rcc <= rcc + 3'h1;
    rctick <= (rcc == 3'h7);
    comp <= (tgt >= ana.trial);
    nwake <= nwake + int'(wake);
  end
  ////////////////////////////////////////
  function automatic logic [15:0] ex(input logic f, input logic [9:0] t);
    return f ? {6'h00, t} : {t, 6'h00};
  endfunction : ex
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wdata <= {24'h000000, v};
    rq.wstrb <= 4'h1;
    rq.bready <= 1'b1;
    fork
      begin
        do @(negedge clk); while (!rs.awready);
        @(posedge clk);
        rq.awvalid <= 1'b0;
      end
      begin
        do @(negedge clk); while (!rs.wready);
        @(posedge clk);
        rq.wvalid <= 1'b0;
      end
    join
    do @(negedge clk); while (!rs.bvalid);
    r = rs.bresp;
    @(posedge clk);
    rq.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do @(negedge clk); while (!rs.arready);
    @(posedge clk);
    rq.arvalid <= 1'b0;
    do @(negedge clk); while (!rs.rvalid);
    d = rs.rdata;
    r = rs.rresp;
    @(posedge clk);
    rq.rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CK(d, {24'h000000, e})
  endtask : rc
  task automatic wdone;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask : wdone
  task automatic conv(input logic [1:0] cs, input logic [9:0] t, input int dv);
    tgt = t;
    wr(8'h04, {fmt, 7'h00});
    wr(8'h00, {cs, t[2:0], 3'h1});
    // acquire on the new channel before go; a real part needs far longer
    repeat (8) @(posedge clk);
    wr(8'h00, {cs, t[2:0], 3'h5});
    wdone;
    `CK(n >= 12 * dv && n <= 13 * dv + 8, 1'b1)
    `CK(ana.channel, t[2:0])
    last = ex(fmt, t);
    rc(8'h08, last[15:8]);
    rc(8'h0C, last[7:0]);
    rc(8'h00, {cs, t[2:0], 3'h1});
    wr(8'h10, 8'h01);
    `CK(done, 1'b0)
    // slowest divider needs 64 clocks of settle before the next go
    repeat (70) @(posedge clk);
  endtask : conv
  task test_done;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h10, 8'h00);
    rd(8'h1C);
    `CK(r, `SADC_RESP_SLVERR)
    wr(8'h1C, 8'h00);
    `CK(r, `SADC_RESP_SLVERR)
    wr(8'h08, 8'hA5);
    `CK(r, `SADC_RESP_OKAY)
    wr(8'h0C, 8'h5A);
    rc(8'h08, 8'hA5);
    rc(8'h0C, 8'h5A);
    wr(8'h00, 8'h04);
    rc(8'h10, 8'h00);
    wr(8'h00, 8'h05);
    rc(8'h10, 8'h02);
    $display("test control done");
    for (int i = 0; i < 3; i++) begin
      fmt = i[0];
      // bit periods scaled down for run time; only the divider ratio matters here
      conv(i[1:0], 10'h2A5 + 10'(i * 211), 2 << (2 * i));
    end
    $display("test conversion done");
    wr(8'h00, 8'h41);
    wr(8'h00, 8'h45);
    repeat (36) @(posedge clk);
    rd(8'h10);
    `CK(d[2:0], 3'h6)
    wr(8'h00, 8'h41);
    `CK(ana.hold_connect, 1'b0)
    repeat (30) @(posedge clk);
    `CK(ana.hold_connect, 1'b1)
    `CK(done, 1'b0)
    rc(8'h08, last[15:8]);
    wr(8'h00, 8'h45);
    repeat (20) @(posedge clk);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h10);
    `CK(d[2:0], 3'h0)
    rd(8'h00);
    `CK(d[0], 1'b1)
    sleep <= 1'b0;
    repeat (40) @(posedge clk);
    $display("test abort done");
    for (int k = 1; k >= 0; k--) begin
      inten <= k[0];
      tgt = k ? 10'h1C3 : 10'h03C;
      w0 = nwake;
      wr(8'h00, 8'hC5);
      sleep <= 1'b1;
      wdone;
      repeat (3) @(negedge clk);
      `CK(nwake - w0, k)
      `CK(ana.powered, k[0])
      last = ex(fmt, tgt);
      rc(8'h08, last[15:8]);
      rd(8'h00);
      `CK(d[2:0], 3'h1)
      sleep <= 1'b0;
      wr(8'h10, 8'h01);
      repeat (30) @(posedge clk);
    end
    wr(8'h14, 8'hF0);
    rc(8'h18, 8'h05);
    $display("test sleep and port done");
    test_done;
  end
  initial begin
    #100000;
    failures++;
    test_done;
  end
endmodule : sadc_seq_tb_top
`default_nettype wire
